// ---- include/hcr_pkg.sv ----
// Purpose: shared constants and types for the host command responder
// Assumes: 100 MHz system clock, byte-wide command and response streams
// Notes: opcodes and error numbers other than 15 are local choices
`default_nettype none
package hcr_pkg;
    // timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned FLASH_TIME_MS = 250;
    localparam int unsigned NS_PER_MS = 1_000_000;
    localparam int unsigned FLASH_CYCLES = (FLASH_TIME_MS * NS_PER_MS) / CLK_PERIOD_NS;
    // message layout
    localparam int unsigned MAX_MSG_LEN = 16;
    localparam int unsigned IDX_COUNT = 0;
    localparam int unsigned IDX_OP = 1;
    localparam int unsigned IDX_ARG = 2;
    localparam logic [7:0] MIN_MSG_LEN = 8'h02;
    localparam logic [7:0] LEN_SLAVE_CMD = 8'h02;
    localparam logic [7:0] LEN_SHOW_CMD = 8'h03;
    // opcodes
    localparam logic [7:0] OP_ENTER_SLAVE = 8'h20;
    localparam logic [7:0] OP_LEAVE_SLAVE = 8'h21;
    localparam logic [7:0] OP_SHOW_CODE = 8'h30;
    // responses
    localparam logic [7:0] RESP_OK = 8'h01;
    localparam logic [7:0] RESP_ERR = 8'h02;
    localparam logic [7:0] LEN_ACK = 8'h02;
    localparam logic [7:0] LEN_ERR = 8'h03;
    // error numbers
    localparam logic [7:0] ERR_BAD_LENGTH = 8'h01;
    localparam logic [7:0] ERR_UNKNOWN_OP = 8'h02;
    localparam logic [7:0] ERR_BAD_VALUE = 8'h03;
    localparam logic [7:0] ERR_NOT_SLAVE = 8'h10;
    localparam logic [7:0] ERR_ALREADY_SLAVE = 8'h0F;
    // display
    localparam logic [7:0] MAX_SHOWN = 8'h63;
    localparam logic [7:0] DECIMAL_BASE = 8'h0A;
    localparam logic [4:0] INIT_STEPS = 5'h06;
    localparam logic [4:0] GAP_STEPS = 5'h04;

    typedef struct packed {
        logic [3:0] tens;
        logic [3:0] units;
        logic rpt;
    } flash_req_t;

    typedef struct packed {
        logic [7:0] len;
        logic [7:0] kind;
        logic [7:0] code;
    } resp_t;
endpackage
`default_nettype wire

// ---- hw/msg_buffer.sv ----
// Purpose: small fifo between response builder and transmitter
// Assumes: both sides on clk_sys
// Notes: depth two by default, stall on out side back-pressures in side
`default_nettype none
module msg_buffer #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 2
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0] wr_ff;
    logic [PW-1:0] rd_ff;
    logic [PW:0] cnt_ff;
    logic push;
    logic pop;

    assign in_ready = (cnt_ff != FULL);
    assign out_valid = (cnt_ff != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_ff[rd_ff];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == LAST) ? '0 : wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= (rd_ff == LAST) ? '0 : rd_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (PW + 1)'(push) - (PW + 1)'(pop);
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    AST_NO_LOSS: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("stalled word changed or vanished");
endmodule // msg_buffer
`default_nettype wire

// ---- hw/led_flasher.sv ----
// Purpose: shows two-digit numbers and the start-up pattern on two leds
// Assumes: tick is a one-cycle pulse per flash half-period
// Notes: a new start request overrides whatever is showing
`default_nettype none
module led_flasher (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // control
    input wire logic tick,
    input wire logic start,
    input wire hcr_pkg::flash_req_t req,
    // leds
    output logic led_red,
    output logic led_green
);
    typedef enum logic [2:0] {F_INIT, F_RED, F_GREEN, F_GAP, F_IDLE} fstate_t;

    fstate_t state_ff;
    hcr_pkg::flash_req_t req_ff;
    logic [4:0] step_ff;
    logic [4:0] red_last;
    logic [4:0] green_last;

    function automatic fstate_t first_state(input hcr_pkg::flash_req_t r);
        if (r.tens != 4'h0) begin
            return F_RED;
        end else if (r.units != 4'h0) begin
            return F_GREEN;
        end
        return F_GAP;
    endfunction

    assign red_last = {req_ff.tens, 1'b0} - 5'h01;
    assign green_last = {req_ff.units, 1'b0} - 5'h01;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_ff <= F_INIT;
            step_ff <= '0;
            req_ff <= '0;
        end else if (start) begin
            req_ff <= req;
            state_ff <= first_state(req);
            step_ff <= '0;
        end else if (tick) begin
            step_ff <= step_ff + 5'h01;
            unique case (state_ff)
                F_INIT: if (step_ff == hcr_pkg::INIT_STEPS - 5'h01) begin
                    state_ff <= F_IDLE;
                end
                F_RED: if (step_ff == red_last) begin
                    step_ff <= '0;
                    state_ff <= (req_ff.units != 4'h0) ? F_GREEN : F_GAP;
                end
                F_GREEN: if (step_ff == green_last) begin
                    step_ff <= '0;
                    state_ff <= F_GAP;
                end
                F_GAP: if (step_ff == hcr_pkg::GAP_STEPS - 5'h01) begin
                    step_ff <= '0;
                    state_ff <= req_ff.rpt ? first_state(req_ff) : F_IDLE;
                end
                F_IDLE: step_ff <= '0;
            endcase
        end
    end

    // init: red, green, red, green, both, dark
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            led_red <= 1'b0;
            led_green <= 1'b0;
        end else begin
            unique case (state_ff)
                F_INIT: begin
                    led_red <= (step_ff == 5'h00) || (step_ff == 5'h02) || (step_ff == 5'h04);
                    led_green <= (step_ff == 5'h01) || (step_ff == 5'h03) || (step_ff == 5'h04);
                end
                F_RED: begin
                    led_red <= !step_ff[0];
                    led_green <= 1'b0;
                end
                F_GREEN: begin
                    led_red <= 1'b0;
                    led_green <= !step_ff[0];
                end
                F_GAP, F_IDLE: begin
                    led_red <= 1'b0;
                    led_green <= 1'b0;
                end
            endcase
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    AST_RED_TENS: assert property (state_ff == F_RED && !step_ff[0] && !start |=> led_red && !led_green)
        else $error("red flash missing during tens");
    AST_REPEAT: assert property (state_ff == F_GAP && tick && !start && req_ff.rpt
            && step_ff == hcr_pkg::GAP_STEPS - 5'h01 |=> state_ff != F_IDLE)
        else $error("error display did not repeat");
    AST_INIT_BOTH: assert property (state_ff == F_INIT && step_ff == 5'h04 |=> led_red && led_green)
        else $error("init pattern lacks both-on step");
endmodule // led_flasher
`default_nettype wire

// ---- hw/host_command_responder.sv ----
// Purpose: collects host command messages, executes them, returns responses
// Assumes: byte streams come from a same-clock serial receiver/transmitter
// Notes: no timeout while collecting; host waits for each response
`default_nettype none
// Function
// - first message byte is the total byte count; it sets bytes collected.
// - short messages wait forever for missing bytes; no timeout, no partial execution.
// - failed or senseless command returns response with error type as second byte.
// - entering slave mode while already slave raises internal error fifteen.
// - display request flashes red once per tens, then green once per units.
// - internal error number flashes repeatedly in the same tens/units pattern.
// - after reset leds flash alternately, then together.
// - enter-slave command makes the radio open for remote connections.
// - successful command without data answers count two then success type.
module host_command_responder #(
    parameter int unsigned FLASH_CYCLES = hcr_pkg::FLASH_CYCLES,
    parameter int unsigned MAX_LEN = hcr_pkg::MAX_MSG_LEN
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // command bytes in
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    // response bytes out
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    // radio and indicators
    output logic radio_discoverable,
    output logic led_red,
    output logic led_green
);
    localparam int unsigned AW = $clog2(MAX_LEN);
    localparam int unsigned DW = $clog2(FLASH_CYCLES);
    localparam logic [7:0] MAX_LEN_B = 8'(MAX_LEN);
    localparam logic [DW-1:0] DIV_LAST = DW'(FLASH_CYCLES - 1);

    typedef enum logic [1:0] {M_IDLE, M_COLLECT, M_EXEC, M_RESP} mstate_t;

    mstate_t state_ff;
    logic [7:0] msg_mem_ff [MAX_LEN];
    logic [7:0] len_ff;
    logic [7:0] idx_ff;
    logic slave_ff;
    hcr_pkg::resp_t resp_ff;
    hcr_pkg::resp_t nxt_resp;
    logic [1:0] ridx_ff;
    logic flash_start_ff;
    hcr_pkg::flash_req_t flash_req_ff;
    logic nxt_flash;
    hcr_pkg::flash_req_t nxt_flash_req;
    logic nxt_slave;
    logic [DW-1:0] div_ff;
    logic tick;
    logic rx_fire;
    logic buf_valid;
    logic buf_ready;
    logic buf_fire;
    logic [7:0] buf_data;
    logic resp_last;
    logic [7:0] op;
    logic [7:0] arg;

    function automatic hcr_pkg::resp_t make_err(input logic [7:0] code);
        return '{len: hcr_pkg::LEN_ERR, kind: hcr_pkg::RESP_ERR, code: code};
    endfunction

    function automatic hcr_pkg::flash_req_t split_digits(input logic [7:0] v, input logic rpt);
        logic [7:0] t;
        logic [7:0] u;
        t = v / hcr_pkg::DECIMAL_BASE;
        u = v % hcr_pkg::DECIMAL_BASE;
        return '{tens: t[3:0], units: u[3:0], rpt: rpt};
    endfunction

    assign rx_ready = (state_ff == M_IDLE) || (state_ff == M_COLLECT);
    assign rx_fire = rx_valid && rx_ready;
    assign op = msg_mem_ff[AW'(hcr_pkg::IDX_OP)];
    assign arg = msg_mem_ff[AW'(hcr_pkg::IDX_ARG)];

    // flash half-period divider
    assign tick = (div_ff == DIV_LAST);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div_ff <= '0;
        end else begin
            div_ff <= tick ? '0 : div_ff + 1'b1;
        end
    end

    // message collection
    always_ff @(posedge clk_sys) begin
        if (rx_fire && (idx_ff < MAX_LEN_B || state_ff == M_IDLE)) begin
            msg_mem_ff[(state_ff == M_IDLE) ? AW'(hcr_pkg::IDX_COUNT) : idx_ff[AW-1:0]] <= rx_data;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_ff <= M_IDLE;
            len_ff <= '0;
            idx_ff <= '0;
            ridx_ff <= '0;
        end else begin
            unique case (state_ff)
                M_IDLE: if (rx_fire) begin
                    len_ff <= rx_data;
                    idx_ff <= 8'h01;
                    state_ff <= (rx_data <= 8'h01) ? M_EXEC : M_COLLECT;
                end
                M_COLLECT: if (rx_fire) begin
                    idx_ff <= idx_ff + 8'h01;
                    if (idx_ff == len_ff - 8'h01) begin
                        state_ff <= M_EXEC;
                    end
                end
                M_EXEC: begin
                    ridx_ff <= '0;
                    state_ff <= M_RESP;
                end
                M_RESP: if (buf_fire) begin
                    ridx_ff <= ridx_ff + 2'h1;
                    if (resp_last) begin
                        state_ff <= M_IDLE;
                    end
                end
            endcase
        end
    end

    // command execution
    always_comb begin
        nxt_resp = '{len: hcr_pkg::LEN_ACK, kind: hcr_pkg::RESP_OK, code: 8'h00};
        nxt_flash = 1'b0;
        nxt_flash_req = flash_req_ff;
        nxt_slave = slave_ff;
        if (len_ff < hcr_pkg::MIN_MSG_LEN || len_ff > MAX_LEN_B) begin
            nxt_resp = make_err(hcr_pkg::ERR_BAD_LENGTH);
        end else begin
            unique case (op)
                hcr_pkg::OP_ENTER_SLAVE: begin
                    if (len_ff != hcr_pkg::LEN_SLAVE_CMD) begin
                        nxt_resp = make_err(hcr_pkg::ERR_BAD_LENGTH);
                    end else if (slave_ff) begin
                        nxt_resp = make_err(hcr_pkg::ERR_ALREADY_SLAVE);
                        nxt_flash = 1'b1;
                        nxt_flash_req = split_digits(hcr_pkg::ERR_ALREADY_SLAVE, 1'b1);
                    end else begin
                        nxt_slave = 1'b1;
                    end
                end
                hcr_pkg::OP_LEAVE_SLAVE: begin
                    if (len_ff != hcr_pkg::LEN_SLAVE_CMD) begin
                        nxt_resp = make_err(hcr_pkg::ERR_BAD_LENGTH);
                    end else if (!slave_ff) begin
                        nxt_resp = make_err(hcr_pkg::ERR_NOT_SLAVE);
                    end else begin
                        nxt_slave = 1'b0;
                    end
                end
                hcr_pkg::OP_SHOW_CODE: begin
                    if (len_ff != hcr_pkg::LEN_SHOW_CMD) begin
                        nxt_resp = make_err(hcr_pkg::ERR_BAD_LENGTH);
                    end else if (arg > hcr_pkg::MAX_SHOWN) begin
                        nxt_resp = make_err(hcr_pkg::ERR_BAD_VALUE);
                    end else begin
                        nxt_flash = 1'b1;
                        nxt_flash_req = split_digits(arg, 1'b0);
                    end
                end
                default: nxt_resp = make_err(hcr_pkg::ERR_UNKNOWN_OP);
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            resp_ff <= '0;
            slave_ff <= 1'b0;
            flash_start_ff <= 1'b0;
            flash_req_ff <= '0;
        end else begin
            flash_start_ff <= 1'b0;
            if (state_ff == M_EXEC) begin
                resp_ff <= nxt_resp;
                slave_ff <= nxt_slave;
                flash_start_ff <= nxt_flash;
                flash_req_ff <= nxt_flash_req;
            end
        end
    end

    assign radio_discoverable = slave_ff;

    // response serialisation
    always_comb begin
        unique case (ridx_ff)
            2'h0: buf_data = resp_ff.len;
            2'h1: buf_data = resp_ff.kind;
            default: buf_data = resp_ff.code;
        endcase
    end

    assign buf_valid = (state_ff == M_RESP);
    assign buf_fire = buf_valid && buf_ready;
    assign resp_last = ({6'h00, ridx_ff} == resp_ff.len - 8'h01);

    msg_buffer #(
        .WIDTH(8),
        .DEPTH(2)
    ) u_resp_buf (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_valid(buf_valid),
        .in_data(buf_data),
        .in_ready(buf_ready),
        .out_valid(tx_valid),
        .out_data(tx_data),
        .out_ready(tx_ready)
    );

    led_flasher u_flasher (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(tick),
        .start(flash_start_ff),
        .req(flash_req_ff),
        .led_red(led_red),
        .led_green(led_green)
    );

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence seq_ok_exec;
        state_ff == M_EXEC && nxt_resp.kind == hcr_pkg::RESP_OK;
    endsequence

    sequence seq_ack_bytes;
        buf_fire && buf_data == hcr_pkg::LEN_ACK ##[1:8] buf_fire && buf_data == hcr_pkg::RESP_OK;
    endsequence

    AST_COUNT_TAKEN: assert property (state_ff == M_IDLE && rx_fire |=> len_ff == $past(rx_data))
        else $error("count byte not captured");
    AST_EXEC_ON_COUNT: assert property (state_ff == M_COLLECT && rx_fire && idx_ff == len_ff - 8'h01
            |=> state_ff == M_EXEC)
        else $error("message not executed at its count");
    AST_WAIT_FOREVER: assert property (state_ff == M_COLLECT && !rx_valid |=> state_ff == M_COLLECT)
        else $error("collection left without bytes");
    AST_ERR_SECOND: assert property (buf_fire && ridx_ff == 2'h1 && resp_ff.len == hcr_pkg::LEN_ERR
            |-> buf_data == hcr_pkg::RESP_ERR)
        else $error("error type not in second byte");
    AST_SLAVE_TWICE: assert property (state_ff == M_EXEC && slave_ff && op == hcr_pkg::OP_ENTER_SLAVE
            && len_ff == hcr_pkg::LEN_SLAVE_CMD |=> resp_ff.code == hcr_pkg::ERR_ALREADY_SLAVE
            && flash_start_ff && flash_req_ff.rpt)
        else $error("repeated slave entry not flagged");
    AST_SLAVE_ON: assert property (state_ff == M_EXEC && !slave_ff && op == hcr_pkg::OP_ENTER_SLAVE
            && len_ff == hcr_pkg::LEN_SLAVE_CMD |=> radio_discoverable)
        else $error("radio not opened on slave entry");
    AST_ACK: assert property (seq_ok_exec |=> ##[0:8] seq_ack_bytes)
        else $error("success not acknowledged with two bytes");
    AST_ERR_NUMBER: assert property (buf_fire && ridx_ff == 2'h2 |-> buf_data == resp_ff.code
            && resp_ff.kind == hcr_pkg::RESP_ERR)
        else $error("error number not after error type");
endmodule // host_command_responder
`default_nettype wire

// ---- sim/host_model.sv ----
// Purpose: host model feeding command bytes and draining response bytes
// Assumes: same clock as the responder
// Notes: a released data line shows the inverse of the last byte
`default_nettype none
module host_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // command bytes
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic rx_ready,
    // response bytes
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic slow = 1'b0;
    logic stuck = 1'b0;
    logic [2:0] pace = 3'h0;
    logic [7:0] got[$];
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b1;
    end
    // entered just after a rising edge; byte held until the edge that takes it
    task automatic send_byte(input logic [7:0] b, input logic last);
        int n;
        n = 0;
        rx_valid <= 1'b1;
        rx_data <= b;
        do begin
            @(negedge clk_sys);
            n++;
        end while (rx_ready !== 1'b1 && n < 60);
        if (rx_ready !== 1'b1) begin
            stuck = 1'b1;
        end
        @(posedge clk_sys);
        if (last) begin
            rx_valid <= 1'b0;
            rx_data <= ~b;
        end
    endtask
    // slow mode takes one byte in eight
    always @(posedge clk_sys) begin
        pace <= pace + 3'h1;
        tx_ready <= !slow || pace == 3'h7;
        if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
        end
    end
endmodule // host_model
`default_nettype wire

// ---- sim/host_command_responder_bench.sv ----
// Purpose: self-checking bench for the host command responder
// Assumes: short flash tick so the led patterns fit the run
// Notes: reset and init pattern first, then table rows, led, short-message and reset cases
`default_nettype none
module host_command_responder_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned FC = 4;
    typedef struct {
        logic [23:0] msg;
        int n;
        logic [23:0] rsp;
        int rn;
        logic disc;
    } row_t;
    logic clk_sys;
    logic rst;
    wire logic rx_valid;
    wire logic [7:0] rx_data;
    wire logic rx_ready;
    wire logic tx_valid;
    wire logic [7:0] tx_data;
    wire logic tx_ready;
    wire logic radio_discoverable;
    wire logic led_red;
    wire logic led_green;
    logic [1:0] prev = 2'h0;
    logic [1:0] led_log[$];
    int err_count = 0;
    int checks_done = 0;
    row_t rows[11];

    host_command_responder #(.FLASH_CYCLES(FC), .MAX_LEN(16)) DUT (
        .clk_sys(clk_sys), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .radio_discoverable(radio_discoverable), .led_red(led_red), .led_green(led_green)
    );
    host_model host (
        .clk_sys(clk_sys), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // log of every change of the led pair
    always @(posedge clk_sys) begin
        if (!rst && {led_red, led_green} !== prev) begin
            led_log.push_back({led_red, led_green});
        end
        prev <= {led_red, led_green};
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic send(input logic [23:0] msg, input int n);
        int i;
        for (i = 0; i < n; i++) begin
            host.send_byte(msg[23 - 8 * i -: 8], i == n - 1);
        end
        if (host.stuck) begin
            err_count++;
            report_and_stop();
        end
    endtask
    // host waits for the whole response before its next message
    task automatic expect_rsp(input logic [23:0] rsp, input int rn);
        int i;
        for (i = 0; i < 400 && host.got.size() < rn; i++) @(posedge clk_sys);
        if (host.got.size() < rn) begin
            err_count++;
            report_and_stop();
        end
        repeat (8) @(posedge clk_sys);
        check("resp_len", 8'(host.got.size()), 8'(rn));
        for (i = 0; i < rn; i++) check("resp_byte", host.got[i], rsp[23 - 8 * i -: 8]);
        host.got.delete();
    endtask
    task automatic check_log(input logic [1:0] exp[$], input logic exact);
        int i;
        if (exact) check("led_changes", 8'(led_log.size()), 8'(exp.size()));
        else check("led_changes", 8'(led_log.size() >= exp.size()), 8'h01);
        for (i = 0; i < exp.size() && i < led_log.size(); i++)
            check("led_state", 8'(led_log[i]), 8'(exp[i]));
        led_log.delete();
    endtask

    initial begin
        int i;
        rst = 1'b1;
        rows[0] = '{24'h022000, 2, 24'h020100, 2, 1'b1};
        rows[1] = '{24'h022000, 2, 24'h03020F, 3, 1'b1};
        rows[2] = '{24'h022100, 2, 24'h020100, 2, 1'b0};
        rows[3] = '{24'h022100, 2, 24'h030210, 3, 1'b0};
        rows[4] = '{24'h033063, 3, 24'h020100, 2, 1'b0};
        rows[5] = '{24'h033064, 3, 24'h030203, 3, 1'b0};
        rows[6] = '{24'h025500, 2, 24'h030202, 3, 1'b0};
        rows[7] = '{24'h023000, 2, 24'h030201, 3, 1'b0};
        rows[8] = '{24'h010000, 1, 24'h030201, 3, 1'b0};
        rows[9] = '{24'h000000, 1, 24'h030201, 3, 1'b0};
        rows[10] = '{24'h033000, 3, 24'h020100, 2, 1'b0};
        repeat (2) @(posedge clk_sys);
        check("reset_state", {3'h0, rx_ready, tx_valid, radio_discoverable, led_red, led_green}, 8'h10);
        rst <= 1'b0;
        repeat (80) @(posedge clk_sys);
        check_log('{2'h2, 2'h1, 2'h2, 2'h1, 2'h3, 2'h0}, 1'b1);
        for (i = 0; i < 11; i++) begin
            host.slow <= i[0];
            send(rows[i].msg, rows[i].n);
            expect_rsp(rows[i].rsp, rows[i].rn);
            check("discoverable", {7'h00, radio_discoverable}, {7'h00, rows[i].disc});
        end
        host.slow <= 1'b0;
        repeat (300) @(posedge clk_sys);
        led_log.delete();
        send(24'h033016, 3);
        expect_rsp(24'h020100, 2);
        repeat (150) @(posedge clk_sys);
        check_log('{2'h2, 2'h0, 2'h2, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0}, 1'b1);
        send(24'h022000, 2);
        expect_rsp(24'h020100, 2);
        send(24'h022000, 2);
        expect_rsp(24'h03020F, 3);
        repeat (200) @(posedge clk_sys);
        check_log('{2'h2, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h1, 2'h0, 2'h2}, 1'b0);
        check("discoverable", {7'h00, radio_discoverable}, 8'h01);
        // over-long message: extra bytes dropped, length refused
        for (i = 0; i < 17; i++) host.send_byte((i == 0) ? 8'h11 : 8'h00, i == 16);
        expect_rsp(24'h030201, 3);
        send(24'h033000, 2);
        repeat (50) @(posedge clk_sys);
        check("short_wait", {6'h00, rx_ready, tx_valid}, 8'h02);
        check("short_resp", 8'(host.got.size()), 8'h00);
        send(24'h050000, 1);
        expect_rsp(24'h020100, 2);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        check("reset_state", {3'h0, rx_ready, tx_valid, radio_discoverable, led_red, led_green}, 8'h10);
        rst <= 1'b0;
        @(posedge clk_sys);
        report_and_stop();
    end
endmodule // host_command_responder_bench
`default_nettype wire
